// ---- watchdog_pkg.sv ----
package watchdog_pkg;

  // ------------------------------------------------------------
  // register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_MODE    = 12'h300;
  localparam logic [11:0] IDX_COMMAND = 12'h301;
  localparam logic [11:0] IDX_STATUS  = 12'h302;
  localparam logic [11:0] IDX_MASK    = 12'h303;
  localparam logic [13:0] ADDR_MODE    = {IDX_MODE, 2'b00};
  localparam logic [13:0] ADDR_COMMAND = {IDX_COMMAND, 2'b00};
  localparam logic [13:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
  localparam logic [13:0] ADDR_MASK    = {IDX_MASK, 2'b00};

  // ------------------------------------------------------------
  // mode register fields
  // ------------------------------------------------------------
  localparam int         MODE_ENABLE_BIT = 7;
  localparam int         MODE_PERIOD_HI  = 6;
  localparam int         MODE_PERIOD_LO  = 5;
  localparam int         MODE_SECOND_IDLE_BIT  = 2;
  localparam int         MODE_ROUTE_BIT  = 1;
  localparam logic [1:0] PERIOD_RESET    = 2'h0;
  localparam logic       ENABLE_RESET    = 1'b1;
  localparam logic       SECOND_IDLE_RESET     = 1'b0;
  localparam logic       ROUTE_RESET     = 1'b0;

  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_DISABLE = 8'hb1;
  localparam logic [7:0] CODE_CLEAR   = 8'h4e;

  // ------------------------------------------------------------
  // counter and tap masks (low bits all ones = period elapsed)
  // ------------------------------------------------------------
  localparam int          CNT_STAGES = 22;
  localparam logic [21:0] TAP_MASK_15 = 22'h007fff;
  localparam logic [21:0] TAP_MASK_17 = 22'h01ffff;
  localparam logic [21:0] TAP_MASK_19 = 22'h07ffff;
  localparam logic [21:0] TAP_MASK_21 = 22'h1fffff;

  // ------------------------------------------------------------
  // internal reset length in clock states
  // ------------------------------------------------------------
  localparam int         RST_MIN_STATES = 22;
  localparam int         RST_MAX_STATES = 29;
  localparam logic [4:0] RST_LEN_STATES = 5'd25;

  // ------------------------------------------------------------
  // interrupt status bits and bus responses
  // ------------------------------------------------------------
  localparam int         STAT_OVERFLOW = 0;
  localparam int         STAT_RESET    = 1;
  localparam int         STAT_BITS     = 2;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// ---- runaway_watchdog_timer.sv ----
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module runaway_watchdog_timer
#(
  parameter int ADDR_W = 14
)
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // power mode state from the clock controller, same clock
  input  wire logic              shallow_idle,
  input  wire logic              second_idle,
  input  wire logic              stop_mode,
  // watchdog outputs
  output logic                   overflow_nmi,
  output logic                   wdt_reset_out,
  output logic                   irq
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam int STAT_W = watchdog_pkg::STAT_BITS;
  logic [ADDR_W-1:0] awaddr_reg;
  logic              aw_full_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              w_full_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic              enable_reg;
  logic [1:0]        period_reg;
  logic              second_idle_run_reg;
  logic              route_reg;
  logic              disabled_reg;
  logic [21:0]       cnt_reg;
  logic              nmi_reg;
  logic [4:0]        rst_cnt_reg;
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] mask_reg;
  logic [STAT_W-1:0] status_next;
  logic [STAT_W-1:0] status_set;
  logic              do_write;
  logic              wr_low;
  logic              mode_wr;
  logic              cmd_wr;
  logic              cmd_clear;
  logic              cmd_disable;
  logic              run;
  logic              over;
  logic [21:0]       tap_mask;
  logic [7:0]        mode_view;

  // ------------------------------------------------------------
  // bus slave: address and data are taken in either order
  // ------------------------------------------------------------
  assign awready  = !aw_full_reg;
  assign wready   = !w_full_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_low   = wstrb_reg[0];
  assign mode_wr  = do_write && wr_low && (awaddr_reg == watchdog_pkg::ADDR_MODE);
  assign cmd_wr   = do_write && wr_low && (awaddr_reg == watchdog_pkg::ADDR_COMMAND);
  assign cmd_clear   = cmd_wr && (wdata_reg[7:0] == watchdog_pkg::CODE_CLEAR);
  assign cmd_disable = cmd_wr && (wdata_reg[7:0] == watchdog_pkg::CODE_DISABLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_full_reg <= 1'b1;
      awaddr_reg  <= awaddr;
    end
    else if (do_write)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end
    else if (wvalid && wready)
    begin
      w_full_reg <= 1'b1;
      wdata_reg  <= wdata;
      wstrb_reg  <= wstrb;
    end
    else if (do_write)
      w_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= watchdog_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      case (awaddr_reg)
        watchdog_pkg::ADDR_MODE,
        watchdog_pkg::ADDR_COMMAND,
        watchdog_pkg::ADDR_STATUS,
        watchdog_pkg::ADDR_MASK: bresp_reg <= watchdog_pkg::RESP_OKAY;
        default:                 bresp_reg <= watchdog_pkg::RESP_SLVERR;
      endcase
    end
    else if (bready)
      bvalid_reg <= 1'b0;
  end

  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

  assign mode_view = {enable_reg, period_reg, 2'b00, second_idle_run_reg, route_reg, 1'b0};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= watchdog_pkg::RESP_OKAY;
      rdata_reg  <= '0;
    end
    else if (arvalid && arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= watchdog_pkg::RESP_OKAY;
      case (araddr)
        watchdog_pkg::ADDR_MODE:    rdata_reg <= {24'h000000, mode_view};
        watchdog_pkg::ADDR_COMMAND: rdata_reg <= 32'h00000000;
        watchdog_pkg::ADDR_STATUS:  rdata_reg <= {30'h00000000, status_reg};
        watchdog_pkg::ADDR_MASK:    rdata_reg <= {30'h00000000, mask_reg};
        default:
        begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= watchdog_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_reg    <= watchdog_pkg::ENABLE_RESET;
      period_reg    <= watchdog_pkg::PERIOD_RESET;
      second_idle_run_reg <= watchdog_pkg::SECOND_IDLE_RESET;
      route_reg     <= watchdog_pkg::ROUTE_RESET;
    end
    else if (mode_wr)
    begin
      enable_reg    <= wdata_reg[watchdog_pkg::MODE_ENABLE_BIT];
      period_reg    <= wdata_reg[watchdog_pkg::MODE_PERIOD_HI:watchdog_pkg::MODE_PERIOD_LO];
      second_idle_run_reg <= wdata_reg[watchdog_pkg::MODE_SECOND_IDLE_BIT];
      route_reg     <= wdata_reg[watchdog_pkg::MODE_ROUTE_BIT];
    end
  end

  // ------------------------------------------------------------
  // enable / disable: two steps so a runaway program cannot stop it
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      disabled_reg <= 1'b0;
    else if (mode_wr && wdata_reg[watchdog_pkg::MODE_ENABLE_BIT])
      disabled_reg <= 1'b0;
    else if (cmd_disable && !enable_reg)
      disabled_reg <= 1'b1;
  end

  // ------------------------------------------------------------
  // binary counter and overflow
  // ------------------------------------------------------------
  assign run = !disabled_reg && !shallow_idle && !stop_mode
               && !(second_idle && !second_idle_run_reg);

  always_comb
  begin
    unique case (period_reg)
      2'h0: tap_mask = watchdog_pkg::TAP_MASK_15;
      2'h1: tap_mask = watchdog_pkg::TAP_MASK_17;
      2'h2: tap_mask = watchdog_pkg::TAP_MASK_19;
      2'h3: tap_mask = watchdog_pkg::TAP_MASK_21;
    endcase
  end

  // a clear in the same cycle as the overflow edge wins: software was in time
  assign over = run && !cmd_clear && ((cnt_reg & tap_mask) == tap_mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (cmd_clear)
      cnt_reg <= '0;
    else if (run)
      cnt_reg <= cnt_reg + 22'h000001;
  end

  // ------------------------------------------------------------
  // non-maskable interrupt and internal reset
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nmi_reg <= 1'b0;
    else
      nmi_reg <= over;
  end

  // only the on-chip reset net is driven; the external pin has no driver here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rst_cnt_reg <= '0;
    else if (over && route_reg)
      rst_cnt_reg <= watchdog_pkg::RST_LEN_STATES;
    else if (rst_cnt_reg != 5'd0)
      rst_cnt_reg <= rst_cnt_reg - 5'd1;
  end

  assign overflow_nmi  = nmi_reg;
  assign wdt_reset_out = (rst_cnt_reg != 5'd0);

  // ------------------------------------------------------------
  // interrupt status and mask; a new event wins over its clear
  // ------------------------------------------------------------
  assign status_set = {over && route_reg, over};

  always_comb
  begin
    status_next = status_reg;
    if (do_write && wr_low && (awaddr_reg == watchdog_pkg::ADDR_STATUS))
      status_next = status_reg & ~wdata_reg[STAT_W-1:0];
    status_next = status_next | status_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= '0;
    else if (do_write && wr_low && (awaddr_reg == watchdog_pkg::ADDR_MASK))
      mask_reg <= wdata_reg[STAT_W-1:0];
  end

  assign irq = |(status_reg & mask_reg);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_defaults: assert property (!$past(aresetn) |-> period_reg == 2'h0 && enable_reg && !route_reg)
    else $error("mode fields not at reset values");
  a_count_advance: assert property (run && !cmd_clear |=> cnt_reg == $past(cnt_reg) + 22'h000001)
    else $error("counter did not advance while running");
  a_clear_code: assert property (cmd_clear |=> cnt_reg == 22'h000000)
    else $error("clear code did not zero the counter");
  a_idle_halt: assert property ((shallow_idle || stop_mode) && !cmd_clear |=> $stable(cnt_reg))
    else $error("counter moved in shallow idle or stop");
  a_second_idle_halt: assert property (second_idle && !second_idle_run_reg && !cmd_clear |=> $stable(cnt_reg))
    else $error("counter moved in second idle with run bit clear");
  a_overflow_tap: assert property (over && period_reg == 2'h0 |-> cnt_reg[14:0] == 15'h7fff)
    else $error("overflow not at selected tap");
  a_nmi_follows: assert property (over |=> overflow_nmi ##1 !overflow_nmi)
    else $error("overflow did not give one nmi pulse");
  a_disable_cause: assert property ($rose(disabled_reg) |-> $past(cmd_disable) && !$past(enable_reg))
    else $error("disabled without the two-step sequence");
  a_enable_write: assert property (mode_wr && wdata_reg[7] |=> !disabled_reg)
    else $error("enable write did not re-enable");
  a_reset_route: assert property (over && !route_reg && !wdt_reset_out |=> !wdt_reset_out)
    else $error("internal reset driven with routing off");
  a_reset_length: assert property ($rose(wdt_reset_out) |-> wdt_reset_out[*8] ##14 wdt_reset_out ##[1:8] !wdt_reset_out)
    else $error("internal reset length outside 22 to 29 states");
  a_cmd_readback: assert property (arvalid && arready && araddr == watchdog_pkg::ADDR_COMMAND |=> rdata == 32'h00000000)
    else $error("command register read back nonzero");

  c_overflow_reset: cover property (over && route_reg ##1 wdt_reset_out);
  c_disabled: cover property ($rose(disabled_reg));
  c_clear_refresh: cover property (cmd_clear && cnt_reg != 22'h000000);
  c_irq_raised: cover property ($rose(irq));

endmodule

// ---- cpu_bus_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// axi4-lite master standing in for software on the core
// ------------------------------------------------------------
module cpu_bus_model
(
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [13:0]      awaddr,
  output logic [2:0]       awprot,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [13:0]      araddr,
  output logic [2:0]       arprot,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial
  begin
    {awaddr, awprot, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // address and data offered together; each dropped once its ready is seen
  task automatic wr(input logic [13:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ---- runaway_watchdog_timer_tb.sv ----
`timescale 1ns/10ps
module runaway_watchdog_timer_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        aclk, aresetn, shallow_idle, second_idle, stop_mode;
  logic [13:0] awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        overflow_nmi, wdt_reset_out, irq;
  int          cyc = 0;
  int          fails = 0;
  int          compares = 0;
  int          t0;
  int          k;

  runaway_watchdog_timer u_runaway_watchdog_timer
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .shallow_idle(shallow_idle), .second_idle(second_idle),
    .stop_mode(stop_mode), .overflow_nmi(overflow_nmi), .wdt_reset_out(wdt_reset_out), .irq(irq)
  );

  cpu_bus_model u_cpu_bus_model
  (
    .aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // ------------------------------------------------------------
  // clock, cycle count, watchdog
  // ------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  // the whole run needs about 80k cycles
  initial
  begin
    #(100000 * 40);
    fails++;
    summarize();
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic w(input logic [13:0] a, input logic [7:0] v, input logic [1:0] er);
    logic [1:0] r;
    u_cpu_bus_model.wr(a, v, r);
    chk(32'(r), 32'(er));
  endtask

  task automatic rchk(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    u_cpu_bus_model.rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask

  // bus turnarounds blur the halt spans by a few cycles, a missed halt or clear by far more
  task automatic nmi_at(input int t, input int e);
    int dv;
    while (overflow_nmi !== 1'b1) @(posedge aclk);
    dv = cyc - t - e;
    if (dv >= -12 && dv <= 12) dv = 0;
    chk(32'(dv), 32'h0);
  endtask

  task automatic halt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    shallow_idle = 1'b0;
    second_idle = 1'b0;
    stop_mode = 1'b0;
    halt(4);
    aresetn <= 1'b1;
    t0 = cyc;
    chk(32'({irq, wdt_reset_out, overflow_nmi}), 32'h0);
    rchk(watchdog_pkg::ADDR_MODE, 32'h80, watchdog_pkg::RESP_OKAY);
    rchk(watchdog_pkg::ADDR_COMMAND, 32'h0, watchdog_pkg::RESP_OKAY);
    rchk(watchdog_pkg::ADDR_STATUS, 32'h0, watchdog_pkg::RESP_OKAY);
    rchk(watchdog_pkg::ADDR_MASK, 32'h0, watchdog_pkg::RESP_OKAY);
    w(watchdog_pkg::ADDR_COMMAND, 8'h55, watchdog_pkg::RESP_OKAY);
    w(watchdog_pkg::ADDR_COMMAND, watchdog_pkg::CODE_DISABLE, watchdog_pkg::RESP_OKAY);
    w(watchdog_pkg::ADDR_MODE, 8'h00, watchdog_pkg::RESP_OKAY);
    rchk(watchdog_pkg::ADDR_MODE, 32'h00, watchdog_pkg::RESP_OKAY);
    halt(3000);
    w(watchdog_pkg::ADDR_COMMAND, watchdog_pkg::CODE_DISABLE, watchdog_pkg::RESP_OKAY);
    halt(3000);
    w(watchdog_pkg::ADDR_MODE, 8'h80, watchdog_pkg::RESP_OKAY);
    shallow_idle <= 1'b1;
    halt(3000);
    shallow_idle <= 1'b0;
    stop_mode <= 1'b1;
    halt(3000);
    stop_mode <= 1'b0;
    second_idle <= 1'b1;
    halt(3000);
    second_idle <= 1'b0;
    nmi_at(t0, 32768 + 12000);
    chk(32'({irq, wdt_reset_out}), 32'h0);
    @(posedge aclk);
    chk(32'(overflow_nmi), 32'h0);
    rchk(watchdog_pkg::ADDR_STATUS, 32'h1, watchdog_pkg::RESP_OKAY);
    w(watchdog_pkg::ADDR_MASK, 8'h03, watchdog_pkg::RESP_OKAY);
    chk(32'(irq), 32'h1);
    w(watchdog_pkg::ADDR_STATUS, 8'h01, watchdog_pkg::RESP_OKAY);
    chk(32'(irq), 32'h0);
    // second idle with run bit set, reset routed
    w(watchdog_pkg::ADDR_MODE, 8'h86, watchdog_pkg::RESP_OKAY);
    rchk(watchdog_pkg::ADDR_MODE, 32'h86, watchdog_pkg::RESP_OKAY);
    second_idle <= 1'b1;
    w(watchdog_pkg::ADDR_COMMAND, watchdog_pkg::CODE_CLEAR, watchdog_pkg::RESP_OKAY);
    t0 = cyc;
    nmi_at(t0, 32768);
    chk(32'(wdt_reset_out), 32'h1);
    k = 0;
    while (wdt_reset_out === 1'b1 && k < 40)
    begin
      @(posedge aclk);
      k++;
    end
    chk(32'(k >= 22 && k <= 29), 32'h1);
    second_idle <= 1'b0;
    rchk(watchdog_pkg::ADDR_STATUS, 32'h3, watchdog_pkg::RESP_OKAY);
    chk(32'(irq), 32'h1);
    w(watchdog_pkg::ADDR_STATUS, 8'h03, watchdog_pkg::RESP_OKAY);
    chk(32'(irq), 32'h0);
    w(watchdog_pkg::ADDR_MODE, 8'hff, watchdog_pkg::RESP_OKAY);
    rchk(watchdog_pkg::ADDR_MODE, 32'he6, watchdog_pkg::RESP_OKAY);
    w(14'h0d00, 8'h4e, watchdog_pkg::RESP_SLVERR);
    rchk(14'h0d00, 32'h0, watchdog_pkg::RESP_SLVERR);
    summarize();
  end
endmodule
